// [design/cwlo_divider.sv]
// Quadrature LO divider with phase rotation and synchronous divider reset
`timescale 1ns/10ps
`include "cwlo_map.svh"
// What this block does
// - Generate 0 and 90 degree LO by dividing the LO input by 4, 8 or 16.
// - Divide ratio comes from bits 2 to 0 of LO configuration register.
// - Every channel owns a sixteen-step phase shifter of 22.5 degrees per step.
// - Final LO phase flip-flops update only on LO input edges, no added jitter.
// - Reset input edge forces every channel divider into one defined state.
// - Configuration bit selects rising or falling LO edge for reset sampling.
// - Four-bit phase code times 22.5 degrees; odd codes invalid in divide by 4.
module cwlo_divider
  import cwlo_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Classic Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // LO and divider reset pins
  input wire logic i_multi_lo_clock_in,
  input wire logic i_lo_div_reset,
  // Quadrature LO phases per channel
  output logic [`CWLO_CHANNELS-1:0] o_lo_i,
  output logic [`CWLO_CHANNELS-1:0] o_lo_q
);
  localparam int NCH = `CWLO_CHANNELS;
  // ==========================================================================
  // Pin synchronisers
  logic [2:0] lo_sync_reg;
  logic [2:0] lo_sync_next;
  logic [1:0] rst_sync_reg;
  logic [1:0] rst_sync_next;
  logic lo_rise;
  logic lo_fall;
  logic lo_edge;
  always_comb
  begin
    lo_sync_next = {lo_sync_reg[1:0], i_multi_lo_clock_in};
    rst_sync_next = {rst_sync_reg[0], i_lo_div_reset};
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      lo_sync_reg <= 3'h0;
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      lo_sync_reg <= lo_sync_next;
      rst_sync_reg <= rst_sync_next;
    end
  end
  assign lo_rise = lo_sync_reg[1] & ~lo_sync_reg[2];
  assign lo_fall = ~lo_sync_reg[1] & lo_sync_reg[2];
  assign lo_edge = lo_rise | lo_fall;
  // ==========================================================================
  // Registers
  cwlo_cfg_type cfg_reg;
  cwlo_cfg_type cfg_next;
  logic [3:0] phase_reg [NCH];
  logic [3:0] phase_next [NCH];
  logic [2:0] chan_reg;
  logic [2:0] chan_next;
  logic synced_reg;
  logic synced_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic ack_reg;
  logic ack_next;
  logic bus_req;
  logic bus_wr;
  logic [9:0] bus_idx;
  logic invalid_sel;
  logic rst_edge;
  cwlo_div_type div_m;
  assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign bus_wr = bus_req & i_wb_we & i_wb_sel[0];
  assign bus_idx = i_wb_adr[11:2];
  // Divide ratio decode; unlisted codes fall back to divide by 16
  always_comb
  begin
    unique case (cfg_reg.div_code)
      `CWLO_DIV_CODE_4: div_m = CWLO_DIV_FOUR;
      `CWLO_DIV_CODE_8: div_m = CWLO_DIV_EIGHT;
      default: div_m = CWLO_DIV_SIXTEEN;
    endcase
  end
  assign invalid_sel = (div_m == CWLO_DIV_FOUR) && phase_reg[chan_reg][0];
  always_comb
  begin
    cfg_next = cfg_reg;
    phase_next = phase_reg;
    chan_next = chan_reg;
    synced_next = synced_reg;
    rdat_next = 32'h0;
    ack_next = bus_req;
    if (bus_wr)
    begin
      if (bus_idx == `CWLO_IDX_LO_CFG)
      begin
        cfg_next = i_wb_dat[`CWLO_EDGE_BIT:`CWLO_DIV_LSB];
      end
      if (bus_idx == `CWLO_IDX_PHASE)
      begin
        phase_next[chan_reg] = i_wb_dat[`CWLO_PHASE_MSB:`CWLO_PHASE_LSB];
      end
      if (bus_idx == `CWLO_IDX_CHAN_SEL)
      begin
        chan_next = i_wb_dat[`CWLO_CHAN_MSB:`CWLO_CHAN_LSB];
      end
      if (bus_idx == `CWLO_IDX_STATUS && i_wb_dat[`CWLO_STAT_SYNCED_BIT])
      begin
        synced_next = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (rst_edge)
    begin
      synced_next = 1'b1;
    end
    if (bus_req && !i_wb_we)
    begin
      unique case (bus_idx)
        `CWLO_IDX_LO_CFG: rdat_next = {28'h0, cfg_reg};
        `CWLO_IDX_PHASE: rdat_next = {28'h0, phase_reg[chan_reg]};
        `CWLO_IDX_CHAN_SEL: rdat_next = {29'h0, chan_reg};
        `CWLO_IDX_STATUS: rdat_next = {30'h0, synced_reg, invalid_sel};
        default: rdat_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      cfg_reg <= `CWLO_CFG_RESET;
      for (int c = 0; c < NCH; c++)
      begin
        phase_reg[c] <= `CWLO_PHASE_RESET;
      end
      chan_reg <= 3'h0;
      synced_reg <= 1'b0;
      rdat_reg <= 32'h0;
      ack_reg <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      phase_reg <= phase_next;
      chan_reg <= chan_next;
      synced_reg <= synced_next;
      rdat_reg <= rdat_next;
      ack_reg <= ack_next;
    end
  end
  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  // ==========================================================================
  // Divider reset sampling on the selected LO edge
  logic rst_smp_reg;
  logic rst_smp_next;
  logic smp_edge;
  assign smp_edge = cfg_reg.falling_edge_sel ? lo_fall : lo_rise;
  always_comb
  begin
    rst_smp_next = smp_edge ? rst_sync_reg[1] : rst_smp_reg;
  end
  // Only a low to high step resets, so a reset held high realigns once and then lets the dividers run
  assign rst_edge = smp_edge & rst_sync_reg[1] & ~rst_smp_reg;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      rst_smp_reg <= 1'b0;
    end
    else
    begin
      rst_smp_reg <= rst_smp_next;
    end
  end
  // ==========================================================================
  // Per-channel dividers, counting both LO edges (period 2M half cycles)
  logic [4:0] cnt_reg [NCH];
  logic [4:0] cnt_next [NCH];
  logic [NCH-1:0] lo_i_reg;
  logic [NCH-1:0] lo_i_next;
  logic [NCH-1:0] lo_q_reg;
  logic [NCH-1:0] lo_q_next;
  logic [5:0] period;
  logic [5:0] half;
  logic [5:0] quarter;
  assign half = {1'b0, div_m};
  assign period = {div_m, 1'b0};
  assign quarter = {2'h0, div_m[4:1]};
  always_comb
  begin
    logic [5:0] offs;
    logic [5:0] inc;
    logic [5:0] qpos;
    offs = 6'h0;
    inc = 6'h0;
    qpos = 6'h0;
    cnt_next = cnt_reg;
    lo_i_next = lo_i_reg;
    lo_q_next = lo_q_reg;
    for (int c = 0; c < NCH; c++)
    begin
      // Offset is code times 2M/16 half cycles; odd codes round down in divide by 4
      unique case (div_m)
        CWLO_DIV_FOUR: offs = {3'h0, phase_reg[c][3:1]};
        CWLO_DIV_EIGHT: offs = {2'h0, phase_reg[c]};
        default: offs = {1'b0, phase_reg[c], 1'b0};
      endcase
      inc = {1'b0, cnt_reg[c]} + 6'h1;
      if (rst_edge)
      begin
        cnt_next[c] = offs[4:0];
      end
      else if (lo_edge)
      begin
        cnt_next[c] = (inc >= period) ? 5'h0 : inc[4:0];
      end
      qpos = ({1'b0, cnt_next[c]} >= quarter) ? ({1'b0, cnt_next[c]} - quarter)
                                              : ({1'b0, cnt_next[c]} + period - quarter);
      // Phase flops load only on LO edges so divider logic adds no timing spread
      if (lo_edge)
      begin
        lo_i_next[c] = ({1'b0, cnt_next[c]} < half);
        lo_q_next[c] = (qpos < half);
      end
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        cnt_reg[c] <= 5'h0;
      end
      lo_i_reg <= '0;
      lo_q_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      lo_i_reg <= lo_i_next;
      lo_q_reg <= lo_q_next;
    end
  end
  assign o_lo_i = lo_i_reg;
  assign o_lo_q = lo_q_reg;
endmodule // cwlo_divider

// [include/cwlo_map.svh]
// Register offsets, field positions, reset values and codes of the LO divider
`ifndef CWLO_MAP_SVH
`define CWLO_MAP_SVH
// ==========================================================================
// Register indices (byte address is four times the index)
`define CWLO_IDX_PHASE 10'h02d
`define CWLO_IDX_LO_CFG 10'h02e
`define CWLO_IDX_CHAN_SEL 10'h005
`define CWLO_IDX_STATUS 10'h006
// ==========================================================================
// Field positions
`define CWLO_DIV_MSB 2
`define CWLO_DIV_LSB 0
`define CWLO_EDGE_BIT 3
`define CWLO_PHASE_MSB 3
`define CWLO_PHASE_LSB 0
`define CWLO_CHAN_MSB 2
`define CWLO_CHAN_LSB 0
`define CWLO_STAT_INVALID_BIT 0
`define CWLO_STAT_SYNCED_BIT 1
// ==========================================================================
// Divide codes and reset values
`define CWLO_DIV_CODE_4 3'h0
`define CWLO_DIV_CODE_8 3'h1
`define CWLO_DIV_CODE_16 3'h2
`define CWLO_CFG_RESET 4'h0
`define CWLO_PHASE_RESET 4'h0
`define CWLO_CHANNELS 8
`endif

// [include/cwlo_pkg.sv]
// Types shared by the LO divider block
package cwlo_pkg;
  // ==========================================================================
  // Divide ratio M in LO input cycles
  typedef enum logic [4:0]
  {
    CWLO_DIV_FOUR = 5'h04,
    CWLO_DIV_EIGHT = 5'h08,
    CWLO_DIV_SIXTEEN = 5'h10
  } cwlo_div_type;
  // ==========================================================================
  // LO configuration carried as one unit
  typedef struct packed
  {
    logic falling_edge_sel;
    logic [2:0] div_code;
  } cwlo_cfg_type;
endpackage

// [verification/cwlo_divider_props.sv]
// Checker of bus and LO output timing
`timescale 1ns/10ps
`include "cwlo_map.svh"
module cwlo_divider_props
(
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_multi_lo_clock_in,
  input wire logic [`CWLO_CHANNELS-1:0] o_lo_i,
  input wire logic [`CWLO_CHANNELS-1:0] o_lo_q
);
  // ==========================================================
  // Properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // Window of a few cycles covers sync latency
  sequence s_lo_evt;
    $past(i_multi_lo_clock_in, 3) != $past(i_multi_lo_clock_in, 6);
  endsequence
  ack_latency_a: assert property (s_req |=> o_wb_ack) else $error("ack late");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data leaks");
  lo_retime_a: assert property (!$stable(o_lo_i) || !$stable(o_lo_q) |-> s_lo_evt)
    else $error("LO output moved without LO edge");
  lo_spacing_a: assert property (!$stable(o_lo_i) |=> $stable(o_lo_i)[*2]) else $error("LO glitch");
  q_lag_a: assert property ($rose(o_lo_q[0]) |-> o_lo_i[0]) else $error("Q not lagging");
  i_lead_a: assert property ($fell(o_lo_i[0]) |-> o_lo_q[0]) else $error("I not leading");
endmodule // cwlo_divider_props
bind cwlo_divider cwlo_divider_props cwlo_divider_props_inst (.i_core_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb,
  .o_wb_dat, .o_wb_ack, .i_multi_lo_clock_in, .o_lo_i, .o_lo_q);

// [verification/cwlo_divider_test.sv]
// Self-checking bench of the LO divider
`timescale 1ns/10ps
`include "cwlo_map.svh"
module cwlo_divider_test;
  // ==========================================================
  // Signals
  logic i_core_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [11:0] i_wb_adr = 12'h0;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic o_wb_ack, i_multi_lo_clock_in, i_lo_div_reset, run = 1'h0, fsel = 1'h0, req = 1'h0;
  logic [`CWLO_CHANNELS-1:0] o_lo_i, o_lo_q, pi, pq;
  logic [9:0] regs [5] = '{`CWLO_IDX_LO_CFG, `CWLO_IDX_PHASE, `CWLO_IDX_CHAN_SEL, `CWLO_IDX_STATUS, 10'h100};
  int n_errors = 0, total_checks = 0, cycles = 0, edges, launch, t0, tp, t1, tq, m, k;
  cwlo_lo_source cwlo_lo_source_inst (.i_core_clk, .i_run(run), .i_fall_sel(fsel), .i_rst_req(req),
    .o_lo(i_multi_lo_clock_in), .o_rst(i_lo_div_reset), .o_edges(edges), .o_launch(launch));
  cwlo_divider cwlo_divider_inst (.i_core_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_multi_lo_clock_in, .i_lo_div_reset, .o_lo_i, .o_lo_q);
  always #20 i_core_clk = !i_core_clk;
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'h3, w};
    {i_wb_adr, i_wb_dat, i_wb_sel} <= {idx, 2'h0, d, s};
    do @(posedge i_core_clk); while (o_wb_ack !== 1'h1);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'h0;
  endtask
  task automatic lo_wait(input int n);
    int s;
    s = edges;
    while (edges < s + n)
      @(posedge i_core_clk);
  endtask
  // ==========================================================
  // Fall times of I on channels 0 and 1, of Q on channel 0, and hang guard
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    pi <= o_lo_i;
    pq <= o_lo_q;
    if (pi[0] && !o_lo_i[0])
    begin
      tp <= t0;
      t0 <= edges;
    end
    if (pi[1] && !o_lo_i[1])
      t1 <= edges;
    if (pq[0] && !o_lo_q[0])
      tq <= edges;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_reset_n <= 1'h1;
    bus(1'h1, 10'h100, 32'hffff_ffff, 4'hf);
    bus(1'h1, `CWLO_IDX_LO_CFG, 32'hf, 4'h0);
    foreach (regs[i])
    begin
      bus(1'h0, regs[i], 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
    bus(1'h1, `CWLO_IDX_CHAN_SEL, 32'h1, 4'hf);
    bus(1'h1, `CWLO_IDX_PHASE, 32'h3, 4'hf);
    bus(1'h0, `CWLO_IDX_PHASE, 32'h0, 4'hf);
    chk(rd, 32'h3);
    $display("register access done");
    for (k = 0; k < 3; k++)
    begin
      m = 4 << k;
      run <= 1'h0;
      repeat (14) @(posedge i_core_clk);
      fsel <= (k == 1);
      repeat (14) @(posedge i_core_clk);
      bus(1'h1, `CWLO_IDX_LO_CFG, 32'(k + 8 * (k == 1)), 4'hf);
      req <= 1'h1;
      @(posedge i_core_clk);
      req <= 1'h0;
      repeat (4) @(posedge i_core_clk);
      run <= 1'h1;
      lo_wait(6 * m);
      chk(t0 - tp, 2 * m);
      chk(tq - t0, m / 2);
      chk((t0 - t1 + 2 * m) % (2 * m), 3 * m / 8);
      chk((t0 - launch) % (2 * m), m + 1);
      bus(1'h0, `CWLO_IDX_STATUS, 32'h0, 4'hf);
      chk(rd, 32'(2 + (k == 0)));
      bus(1'h1, `CWLO_IDX_STATUS, 32'h2, 4'hf);
      bus(1'h0, `CWLO_IDX_STATUS, 32'h0, 4'hf);
      chk(rd, 32'(k == 0));
      $display("divide by %0d done", m);
    end
    close_out();
  end
endmodule // cwlo_divider_test

// [verification/cwlo_lo_source.sv]
// LO clock source and divider reset generator
`timescale 1ns/10ps
module cwlo_lo_source
(
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic i_fall_sel,
  input wire logic i_rst_req,
  // Pins and counters
  output logic o_lo = 1'b0,
  output logic o_rst = 1'b0,
  output int o_edges = 0,
  output int o_launch = 0
);
  // ==========================================================
  // Stops only after a launch edge, so the next edge samples
  int tick = 0;
  int hold = 0;
  always @(posedge i_core_clk)
  begin
    tick <= (tick == 5) ? 0 : tick + 1;
    if (tick == 5 && (i_run || o_lo != i_fall_sel))
    begin
      o_lo <= !o_lo;
      o_edges <= o_edges + 1;
      hold <= (hold > 0) ? hold - 1 : 0;
      if (hold == 1)
        o_rst <= 1'h0;
    end
    if (i_rst_req)
    begin
      o_rst <= 1'h1;
      o_launch <= o_edges;
      hold <= 2;
    end
  end
endmodule // cwlo_lo_source
